// [src/fppio_pin_mux.sv]
// Per-pin drive mux for one bidirectional port bit.
// Assumes the caller picks the alternate/override source per bit.
`timescale 1ns/1ps
`default_nettype none
module fppio_pin_mux (
    input  wire logic latch,
    input  wire logic bus_sel,
    input  wire logic bus_val,
    input  wire logic alt_en,
    input  wire logic alt_val,
    input  wire logic open_drain,
    output logic      pin_o,
    output logic      pin_oe_n
);
    // ************************************************************
    // Drive selection
    // ************************************************************
    logic level;
    always_comb begin
        if (bus_sel) begin
            level    = bus_val;
            pin_o    = bus_val;
            pin_oe_n = 1'b0;
        end else begin
            level    = alt_en ? (latch & alt_val) : latch;
            pin_o    = level;
            pin_oe_n = open_drain ? level : 1'b0;
        end
    end
endmodule
`default_nettype wire

// [src/fppio_pkg.sv]
// Constants for the four-port parallel I/O block.
// Assumes one core clock and an active-low asynchronous reset.
package fppio_pkg;
    // ************************************************************
    // Widths and port selects
    // ************************************************************
    localparam int          PORT_W      = 8;
    localparam logic [1:0]  PORT_LOWAD  = 2'h0;
    localparam logic [1:0]  PORT_ANALOG = 2'h1;
    localparam logic [1:0]  PORT_HIGHAD = 2'h2;
    localparam logic [1:0]  PORT_ALTFN  = 2'h3;
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0]  LATCH_RST   = 8'hff;
    // ************************************************************
    // Pin positions
    // ************************************************************
    localparam int BIT_T2CNT  = 0;
    localparam int BIT_T2TRIG = 1;
    localparam int BIT_SSEL   = 5;
    localparam int BIT_RXD    = 0;
    localparam int BIT_TXD    = 1;
    localparam int BIT_INT0   = 2;
    localparam int BIT_EXTERNAL_INTERRUPT_ONE   = 3;
    localparam int BIT_T0     = 4;
    localparam int BIT_T1     = 5;
    localparam int BIT_WRS    = 6;
    localparam int BIT_RDS    = 7;
    localparam int BIT_PWM_A  = 6;
    localparam int BIT_PWM_B  = 7;
    // ************************************************************
    // Bit-op kinds for read-modify-write
    // ************************************************************
    typedef enum logic [1:0] {
        FPPIO_BIT_CLR,
        FPPIO_BIT_SET,
        FPPIO_BIT_CPY
    } fppio_bitop_t;
endpackage

// [src/fppio_ports.sv]
// Four 8-bit parallel ports: latches, pin drive and CPU read paths.
// Assumes CPU strobes and pin inputs are synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module fppio_ports #(
    parameter int W = fppio_pkg::PORT_W
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [1:0]   port_sel,
    input  wire logic         wr_latch,
    input  wire logic         rd_latch,
    input  wire logic         rd_pin,
    input  wire logic         rmw_bit,
    input  wire logic [2:0]   rmw_bit_idx,
    input  wire logic [1:0]   rmw_bit_op,
    input  wire logic         rmw_bit_val,
    input  wire logic [W-1:0] wr_data,
    output logic [W-1:0]      rd_data,
    output logic              rd_valid,
    input  wire logic         ext_access,
    input  wire logic         ext_prog_fetch,
    input  wire logic [W-1:0] ext_addr_lo_data,
    input  wire logic [W-1:0] ext_addr_hi,
    input  wire logic [W-1:0] ext_addr_mid,
    input  wire logic [3:0]   pwm_pin_config_register,
    input  wire logic         pwm0,
    input  wire logic         pwm1,
    input  wire logic         serial_en,
    input  wire logic         serial_mode0,
    input  wire logic         serial_txd,
    input  wire logic         serial_m0_data_o,
    input  wire logic         serial_m0_data_oe,
    input  wire logic         serial_m0_clk,
    input  wire logic         spi_miso_en,
    input  wire logic         spi_miso,
    input  wire logic         ext_wr_strobe_n,
    input  wire logic         ext_rd_strobe_n,
    input  wire logic         xdata_strobe_en,
    input  wire logic [W-1:0] p0_i,
    output logic [W-1:0]      p0_o,
    output logic [W-1:0]      p0_oe_n,
    input  wire logic [W-1:0] p1_i,
    output logic [W-1:0]      p1_analog_sel,
    input  wire logic [W-1:0] p2_i,
    output logic [W-1:0]      p2_o,
    output logic [W-1:0]      p2_oe_n,
    input  wire logic [W-1:0] p3_i,
    output logic [W-1:0]      p3_o,
    output logic [W-1:0]      p3_oe_n,
    output logic              timer2_count_input,
    output logic              timer2_capture_trigger,
    output logic              spi_slave_select_n,
    output logic              serial_rx_in,
    output logic              external_interrupt_zero,
    output logic              external_interrupt_one,
    output logic              timer0_count_input,
    output logic              timer1_count_input
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [W-1:0] low_addr_data_port_latch;
        logic [W-1:0] analog_input_port_latch;
        logic [W-1:0] high_addr_port_latch;
        logic [W-1:0] alt_function_port_latch;
        logic [W-1:0] rd_data;
        logic         rd_valid;
    } fppio_state_t;

    fppio_state_t st_q;
    fppio_state_t st_d;

    logic [W-1:0] sel_latch;
    logic [W-1:0] sel_pin;
    logic [W-1:0] rmw_byte;
    logic [W-1:0] p3_alt_en;
    logic [W-1:0] p3_alt_val;
    logic [W-1:0] p2_alt_en;
    logic [W-1:0] p2_alt_val;
    logic [W-1:0] p2_bus_val;
    logic [W-1:0] p3_pwm_ovr;

    // ************************************************************
    // Read path selection
    // ************************************************************
    always_comb begin
        if (port_sel == fppio_pkg::PORT_LOWAD) begin
            sel_latch = st_q.low_addr_data_port_latch;
            sel_pin   = p0_i;
        end else if (port_sel == fppio_pkg::PORT_ANALOG) begin
            sel_latch = st_q.analog_input_port_latch;
            sel_pin   = p1_i;
        end else if (port_sel == fppio_pkg::PORT_HIGHAD) begin
            sel_latch = st_q.high_addr_port_latch;
            sel_pin   = p2_i;
        end else begin
            sel_latch = st_q.alt_function_port_latch;
            sel_pin   = p3_i;
        end
    end

    // Bit form: whole latch byte read, one bit changed
    always_comb begin
        rmw_byte = sel_latch;
        case (fppio_pkg::fppio_bitop_t'(rmw_bit_op))
            fppio_pkg::FPPIO_BIT_CLR: rmw_byte[rmw_bit_idx] = 1'b0;
            fppio_pkg::FPPIO_BIT_SET: rmw_byte[rmw_bit_idx] = 1'b1;
            default:                  rmw_byte[rmw_bit_idx] = rmw_bit_val;
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [W-1:0] wv;
        wv       = rmw_bit ? rmw_byte : wr_data;
        st_d     = st_q;
        st_d.rd_valid = rd_latch | rd_pin;
        if (rd_latch) begin
            st_d.rd_data = sel_latch;
        end else if (rd_pin) begin
            st_d.rd_data = sel_pin;
        end
        if (wr_latch | rmw_bit) begin
            if (port_sel == fppio_pkg::PORT_LOWAD) begin
                st_d.low_addr_data_port_latch = wv;
            end else if (port_sel == fppio_pkg::PORT_ANALOG) begin
                st_d.analog_input_port_latch = wv;
            end else if (port_sel == fppio_pkg::PORT_HIGHAD) begin
                st_d.high_addr_port_latch = wv;
            end else begin
                st_d.alt_function_port_latch = wv;
            end
        end
        if (ext_access) begin
            st_d.low_addr_data_port_latch = fppio_pkg::LATCH_RST;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q.low_addr_data_port_latch <= fppio_pkg::LATCH_RST;
            st_q.analog_input_port_latch  <= fppio_pkg::LATCH_RST;
            st_q.high_addr_port_latch     <= fppio_pkg::LATCH_RST;
            st_q.alt_function_port_latch  <= fppio_pkg::LATCH_RST;
            st_q.rd_data                  <= '0;
            st_q.rd_valid                 <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data  = st_q.rd_data;
    assign rd_valid = st_q.rd_valid;

    // ************************************************************
    // Port 1 and its inputs
    // ************************************************************
    assign p1_analog_sel          = st_q.analog_input_port_latch;
    assign timer2_count_input     = p1_i[fppio_pkg::BIT_T2CNT];
    assign timer2_capture_trigger = p1_i[fppio_pkg::BIT_T2TRIG];
    assign spi_slave_select_n     = p1_i[fppio_pkg::BIT_SSEL];

    // ************************************************************
    // Port 3 alternate inputs
    // ************************************************************
    assign serial_rx_in            = p3_i[fppio_pkg::BIT_RXD];
    assign external_interrupt_zero = p3_i[fppio_pkg::BIT_INT0];
    assign external_interrupt_one  = p3_i[fppio_pkg::BIT_EXTERNAL_INTERRUPT_ONE];
    assign timer0_count_input      = p3_i[fppio_pkg::BIT_T0];
    assign timer1_count_input      = p3_i[fppio_pkg::BIT_T1];

    // ************************************************************
    // Alternate output sources
    // ************************************************************
    always_comb begin
        p3_alt_en  = '0;
        p3_alt_val = '1;
        p3_pwm_ovr = '0;
        p2_alt_en  = '0;
        p2_alt_val = '1;
        if (serial_en && serial_mode0) begin
            p3_alt_en[fppio_pkg::BIT_RXD]  = 1'b1;
            p3_alt_val[fppio_pkg::BIT_RXD] = serial_m0_data_oe ? serial_m0_data_o : 1'b1;
            p3_alt_en[fppio_pkg::BIT_TXD]  = 1'b1;
            p3_alt_val[fppio_pkg::BIT_TXD] = serial_m0_clk;
        end else if (serial_en) begin
            p3_alt_en[fppio_pkg::BIT_TXD]  = 1'b1;
            p3_alt_val[fppio_pkg::BIT_TXD] = serial_txd;
        end
        if (spi_miso_en) begin
            p3_alt_en[fppio_pkg::BIT_EXTERNAL_INTERRUPT_ONE]  = 1'b1;
            p3_alt_val[fppio_pkg::BIT_EXTERNAL_INTERRUPT_ONE] = spi_miso;
        end
        if (pwm_pin_config_register[2]) begin
            p3_alt_en[fppio_pkg::BIT_T0]  = 1'b1;
            p3_alt_val[fppio_pkg::BIT_T0] = pwm0;
            p3_pwm_ovr[fppio_pkg::BIT_T0] = 1'b1;
        end
        if (pwm_pin_config_register[3]) begin
            p3_alt_en[fppio_pkg::BIT_EXTERNAL_INTERRUPT_ONE]  = 1'b1;
            p3_alt_val[fppio_pkg::BIT_EXTERNAL_INTERRUPT_ONE] = pwm1;
            p3_pwm_ovr[fppio_pkg::BIT_EXTERNAL_INTERRUPT_ONE] = 1'b1;
        end
        if (xdata_strobe_en) begin
            p3_alt_en[fppio_pkg::BIT_WRS]  = 1'b1;
            p3_alt_val[fppio_pkg::BIT_WRS] = ext_wr_strobe_n;
            p3_alt_en[fppio_pkg::BIT_RDS]  = 1'b1;
            p3_alt_val[fppio_pkg::BIT_RDS] = ext_rd_strobe_n;
        end
        if (pwm_pin_config_register[0]) begin
            p2_alt_en[fppio_pkg::BIT_PWM_A]  = 1'b1;
            p2_alt_val[fppio_pkg::BIT_PWM_A] = pwm0;
        end
        if (pwm_pin_config_register[1]) begin
            p2_alt_en[fppio_pkg::BIT_PWM_B]  = 1'b1;
            p2_alt_val[fppio_pkg::BIT_PWM_B] = pwm1;
        end
        p2_bus_val = ext_prog_fetch ? ext_addr_hi : ext_addr_mid;
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_pin
            fppio_pin_mux u_p0 (
                .latch      (st_q.low_addr_data_port_latch[i]),
                .bus_sel    (ext_access),
                .bus_val    (ext_addr_lo_data[i]),
                .alt_en     (1'b0),
                .alt_val    (1'b1),
                .open_drain (1'b1),
                .pin_o      (p0_o[i]),
                .pin_oe_n   (p0_oe_n[i])
            );
            fppio_pin_mux u_p2 (
                .latch      (p2_alt_en[i] ? 1'b1 : st_q.high_addr_port_latch[i]),
                .bus_sel    (ext_access & ~p2_alt_en[i]),
                .bus_val    (p2_bus_val[i]),
                .alt_en     (p2_alt_en[i]),
                .alt_val    (p2_alt_val[i]),
                .open_drain (1'b1),
                .pin_o      (p2_o[i]),
                .pin_oe_n   (p2_oe_n[i])
            );
            fppio_pin_mux u_p3 (
                .latch      (p3_pwm_ovr[i] ? 1'b1 : st_q.alt_function_port_latch[i]),
                .bus_sel    (1'b0),
                .alt_en     (p3_alt_en[i]),
                .bus_val    (1'b0),
                .alt_val    (p3_alt_val[i]),
                .open_drain (1'b1),
                .pin_o      (p3_o[i]),
                .pin_oe_n   (p3_oe_n[i])
            );
        end
    endgenerate

    // ************************************************************
    // Checks
    // ************************************************************
    sequence ext_seen_s;
        ext_access;
    endsequence
    sequence p0_all_ones_s;
        st_q.low_addr_data_port_latch == fppio_pkg::LATCH_RST;
    endsequence

    p0_load_ones_a: assert property (@(posedge clock) disable iff (!nrst)
        ext_seen_s |=> p0_all_ones_s) else $error("port 0 latch not all ones after access");
    p0_pushpull_a: assert property (@(posedge clock) disable iff (!nrst)
        ext_access |-> (p0_oe_n == '0 && p0_o == ext_addr_lo_data)) else $error("port 0 not bus driven");
    p0_opendrain_a: assert property (@(posedge clock) disable iff (!nrst)
        !ext_access |-> (p0_oe_n == st_q.low_addr_data_port_latch)) else $error("port 0 drive wrong");
    latch_write_a: assert property (@(posedge clock) disable iff (!nrst)
        (wr_latch && !rmw_bit && port_sel == fppio_pkg::PORT_HIGHAD)
        |=> st_q.high_addr_port_latch == $past(wr_data)) else $error("latch write lost");
    pin_read_a: assert property (@(posedge clock) disable iff (!nrst)
        (rd_pin && !rd_latch && port_sel == fppio_pkg::PORT_ALTFN)
        |=> (rd_valid && rd_data == $past(p3_i))) else $error("pin read wrong");
    p2_latch_keep_a: assert property (@(posedge clock) disable iff (!nrst)
        (ext_access && !wr_latch && !rmw_bit) |=> $stable(st_q.high_addr_port_latch)) else $error("port 2 latch changed");
    p2_pwm_a: assert property (@(posedge clock) disable iff (!nrst)
        pwm_pin_config_register[1] |-> (p2_o[fppio_pkg::BIT_PWM_B] == pwm1)) else $error("pwm override lost");
    p3_stuck_a: assert property (@(posedge clock) disable iff (!nrst)
        !st_q.alt_function_port_latch[fppio_pkg::BIT_TXD] |-> !p3_o[fppio_pkg::BIT_TXD]) else $error("port 3 not held low");
    p1_analog_a: assert property (@(posedge clock) disable iff (!nrst)
        p1_analog_sel == st_q.analog_input_port_latch) else $error("analog select mismatch");

    // ************************************************************
    // Pin function checks
    // ************************************************************
    p3_pwm_ovr_a: assert property (@(posedge clock) disable iff (!nrst)
        pwm_pin_config_register[2] |-> (p3_o[fppio_pkg::BIT_T0] == pwm0))
        else $error("port 3 pwm override lost");
    p2_addr_out_a: assert property (@(posedge clock) disable iff (!nrst)
        (ext_access && pwm_pin_config_register == 4'h0)
        |-> (p2_oe_n == '0 && p2_o == (ext_prog_fetch ? ext_addr_hi : ext_addr_mid)))
        else $error("port 2 address wrong");
    p2_weak_pull_a: assert property (@(posedge clock) disable iff (!nrst)
        (!ext_access && pwm_pin_config_register[1:0] == 2'h0)
        |-> (p2_oe_n == st_q.high_addr_port_latch && p2_o == st_q.high_addr_port_latch))
        else $error("port 2 drive wrong");
    p3_weak_pull_a: assert property (@(posedge clock) disable iff (!nrst)
        (p3_alt_en == '0) |-> (p3_oe_n == st_q.alt_function_port_latch))
        else $error("port 3 drive wrong");
    p1_feed_a: assert property (@(posedge clock) disable iff (!nrst)
        timer2_count_input == p1_i[fppio_pkg::BIT_T2CNT]
        && timer2_capture_trigger == p1_i[fppio_pkg::BIT_T2TRIG]
        && spi_slave_select_n == p1_i[fppio_pkg::BIT_SSEL])
        else $error("port 1 feed wrong");
    p3_feed_a: assert property (@(posedge clock) disable iff (!nrst)
        serial_rx_in == p3_i[fppio_pkg::BIT_RXD]
        && timer0_count_input == p3_i[fppio_pkg::BIT_T0]
        && timer1_count_input == p3_i[fppio_pkg::BIT_T1])
        else $error("port 3 feed wrong");
    m0_clock_a: assert property (@(posedge clock) disable iff (!nrst)
        (serial_en && serial_mode0 && st_q.alt_function_port_latch[fppio_pkg::BIT_TXD])
        |-> (p3_o[fppio_pkg::BIT_TXD] == serial_m0_clk))
        else $error("mode 0 clock lost");
    rd_pulse_a: assert property (@(posedge clock) disable iff (!nrst)
        !(rd_latch || rd_pin) |=> !rd_valid)
        else $error("read valid not a pulse");
endmodule
`default_nettype wire

// [verif/four_port_parallel_io_tb_top.sv]
// Testbench: integer latch model compared with the four-port block.
// Assumes fppio_ports and the board model; inputs change at falling edge.
`timescale 1ns/1ps
`default_nettype none
module four_port_parallel_io_tb_top;
    logic       clock, nrst, wr_latch, rd_latch, rd_pin, rmw_bit, rmw_bit_val, rd_valid;
    logic [1:0] port_sel, rmw_bit_op;
    logic [2:0] rmw_bit_idx;
    logic [7:0] wr_data, rd_data, ext_addr_lo_data, ext_addr_hi, ext_addr_mid, ext_en, ext_val, p1_src;
    logic [7:0] p0_i, p0_o, p0_oe_n, p1_i, p1_analog_sel, p2_i, p2_o, p2_oe_n, p3_i, p3_o, p3_oe_n;
    logic [3:0] pwm_pin_config_register;
    logic       ext_access, ext_prog_fetch, pwm0, pwm1, serial_en, serial_mode0, serial_txd;
    logic       serial_m0_data_o, serial_m0_data_oe, serial_m0_clk, spi_miso_en, spi_miso;
    logic       ext_wr_strobe_n, ext_rd_strobe_n, xdata_strobe_en, timer2_count_input, timer2_capture_trigger;
    logic       spi_slave_select_n, serial_rx_in, external_interrupt_zero, external_interrupt_one;
    logic       timer0_count_input, timer1_count_input;
    int         lat [4];
    int         seed = 88181;
    int         err_total = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    int         p, e;
    logic [7:0] d;
    fppio_ports i_fppio_ports (.clock, .nrst, .port_sel, .wr_latch, .rd_latch, .rd_pin, .rmw_bit, .rmw_bit_idx,
        .rmw_bit_op, .rmw_bit_val, .wr_data, .rd_data, .rd_valid, .ext_access, .ext_prog_fetch, .ext_addr_lo_data,
        .ext_addr_hi, .ext_addr_mid, .pwm_pin_config_register, .pwm0, .pwm1, .serial_en, .serial_mode0, .serial_txd,
        .serial_m0_data_o, .serial_m0_data_oe, .serial_m0_clk, .spi_miso_en, .spi_miso, .ext_wr_strobe_n,
        .ext_rd_strobe_n, .xdata_strobe_en, .p0_i, .p0_o, .p0_oe_n, .p1_i, .p1_analog_sel, .p2_i, .p2_o, .p2_oe_n,
        .p3_i, .p3_o, .p3_oe_n, .timer2_count_input, .timer2_capture_trigger, .spi_slave_select_n, .serial_rx_in,
        .external_interrupt_zero, .external_interrupt_one, .timer0_count_input, .timer1_count_input);
    fppio_board i_fppio_board (.p0_o, .p0_oe_n, .p2_o, .p2_oe_n, .p3_o, .p3_oe_n, .ext_en, .ext_val, .p1_src,
        .p0_i, .p1_i, .p2_i, .p3_i);
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic print_verdict();
        if (err_total == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [7:0] pinx(input int q);
        return (q == 1) ? p1_src : (8'(lat[q]) & (~ext_en | ext_val));
    endfunction
    task automatic req(input int kind, input int q, input logic [7:0] v);
        @(negedge clock);
        port_sel = 2'(q);
        wr_data = v;
        wr_latch = (kind == 0);
        rd_latch = (kind == 1);
        rd_pin = (kind == 2);
        rmw_bit = (kind == 3);
        @(negedge clock);
        {wr_latch, rd_latch, rd_pin, rmw_bit} = 4'h0;
    endtask
    task automatic rdchk(input int q);
        req(1, q, 8'h00);
        chk("rd_latch", rd_data, 8'(lat[q]));
        chk("rd_valid", {7'h00, rd_valid}, 8'h01);
        req(2, q, 8'h00);
        chk("rd_pin", rd_data, pinx(q));
    endtask
    task automatic wr(input int q, input logic [7:0] v);
        req(0, q, v);
        lat[q] = int'(v);
    endtask
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            print_verdict();
        end
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {nrst, port_sel, wr_latch, rd_latch, rd_pin, rmw_bit, rmw_bit_idx, rmw_bit_op, rmw_bit_val} = '0;
        {wr_data, ext_access, ext_prog_fetch, ext_addr_lo_data, ext_addr_hi, ext_addr_mid} = '0;
        {pwm_pin_config_register, pwm0, pwm1, serial_en, serial_mode0, serial_txd, serial_m0_clk} = '0;
        {serial_m0_data_o, serial_m0_data_oe, spi_miso_en, spi_miso, xdata_strobe_en, ext_en, ext_val, p1_src} = '0;
        {ext_wr_strobe_n, ext_rd_strobe_n} = 2'h3;
        repeat (10) @(negedge clock);
        nrst = 1'h1;
        for (int q = 0; q < 4; q++) lat[q] = 255;
        chk("p1_analog_sel", p1_analog_sel, 8'hff);
        chk("p0_oe_n", p0_oe_n, 8'hff);
        chk("p2_p3_pins", p2_i & p3_i, 8'hff);
        for (int q = 0; q < 4; q++) rdchk(q);
        repeat (24) begin
            p = $random(seed) & 3;
            d = 8'($random(seed));
            ext_en = 8'($random(seed));
            ext_val = 8'($random(seed));
            p1_src = 8'($random(seed));
            wr(p, d);
            rdchk(p);
            chk("p0_oe_n", p0_oe_n, 8'(lat[0]));
            chk("p0_o_low", p0_o | 8'(lat[0]), 8'(lat[0]));
            chk("p1_analog_sel", p1_analog_sel, 8'(lat[1]));
            chk("p2_pin", p2_i, pinx(2));
            chk("p3_pin", p3_i, pinx(3));
            chk("p1_copies", {5'h00, spi_slave_select_n, timer2_capture_trigger, timer2_count_input},
                {5'h00, p1_src[5], p1_src[1:0]});
            chk("p3_copies", {3'h0, timer1_count_input, timer0_count_input, external_interrupt_one,
                external_interrupt_zero, serial_rx_in}, {3'h0, p3_i[5:2], p3_i[0]});
        end
        for (int op = 0; op < 3; op++) begin
            repeat (3) begin
                p = $random(seed) & 3;
                rmw_bit_idx = 3'($random(seed));
                rmw_bit_val = 1'($random(seed));
                rmw_bit_op = 2'(op);
                e = lat[p];
                if (op == 1 || (op == 2 && rmw_bit_val)) e = e | (1 << rmw_bit_idx);
                else e = e & ~(1 << rmw_bit_idx);
                req(3, p, 8'h00);
                lat[p] = e & 255;
                rdchk(p);
            end
        end
        ext_en = 8'h00;
        wr(0, 8'h00);
        wr(2, 8'h3c);
        {ext_addr_lo_data, ext_addr_hi, ext_addr_mid} = 24'($random(seed));
        ext_access = 1'h1;
        ext_prog_fetch = 1'h1;
        wr(0, 8'h12);
        chk("p0_o_ext", p0_o, ext_addr_lo_data);
        chk("p0_oe_n_ext", p0_oe_n, 8'h00);
        chk("p2_o_fetch", p2_o, ext_addr_hi);
        chk("p2_oe_n_ext", p2_oe_n, 8'h00);
        ext_prog_fetch = 1'h0;
        #10;
        chk("p2_o_data", p2_o, ext_addr_mid);
        @(negedge clock);
        ext_access = 1'h0;
        lat[0] = 255;
        rdchk(0);
        rdchk(2);
        wr(2, 8'h00);
        wr(3, 8'h00);
        for (int i = 0; i < 64; i++) begin
            {pwm_pin_config_register, pwm1, pwm0} = 6'(i);
            #10;
            chk("pwm_p2", p2_i & 8'hc0, {pwm_pin_config_register[1] & pwm1,
                pwm_pin_config_register[0] & pwm0, 6'h00});
            chk("pwm_p3", p3_i & 8'h18, {3'h0, pwm_pin_config_register[2] & pwm0,
                pwm_pin_config_register[3] & pwm1, 3'h0});
            @(negedge clock);
        end
        pwm_pin_config_register = 4'h0;
        {serial_en, xdata_strobe_en, spi_miso_en, serial_m0_data_oe} = 4'hf;
        for (int i = 0; i < 16; i++) begin
            wr(3, (i & 1) ? 8'hff : 8'h00);
            serial_mode0 = 1'(i >> 1);
            {serial_txd, serial_m0_clk, serial_m0_data_o, spi_miso, ext_wr_strobe_n, ext_rd_strobe_n} =
                6'($random(seed));
            #10;
            chk("p3_alt", p3_i & 8'hcb, 8'(lat[3]) & {ext_rd_strobe_n, ext_wr_strobe_n, 2'h0, spi_miso, 1'h0,
                serial_mode0 ? serial_m0_clk : serial_txd, serial_mode0 ? serial_m0_data_o : 1'h1});
        end
        {serial_en, xdata_strobe_en, spi_miso_en, serial_mode0} = 4'h0;
        print_verdict();
    end
endmodule
`default_nettype wire

// [verif/fppio_board.sv]
// Board model: pin wiring of the four ports, pull-ups and external drivers of ports 0, 2 and 3.
// Assumes oe_n low means the block drives the pin; port 0 has board pull-ups.
`timescale 1ns/1ps
`default_nettype none
module fppio_board (
    input  wire logic [7:0] p0_o,
    input  wire logic [7:0] p0_oe_n,
    input  wire logic [7:0] p2_o,
    input  wire logic [7:0] p2_oe_n,
    input  wire logic [7:0] p3_o,
    input  wire logic [7:0] p3_oe_n,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] p1_src,
    output logic [7:0]      p0_i,
    output logic [7:0]      p1_i,
    output logic [7:0]      p2_i,
    output logic [7:0]      p3_i
);
    // ************************************************************
    // Wire level per pin
    // ************************************************************
    function automatic logic [7:0] res(input logic [7:0] o, input logic [7:0] oe_n, input logic [7:0] en,
                                       input logic [7:0] v);
        for (int b = 0; b < 8; b++) begin
            res[b] = !oe_n[b] ? o[b] : (en[b] ? v[b] : 1'h1);
        end
    endfunction
    assign p0_i = res(p0_o, p0_oe_n, ext_en, ext_val);
    assign p1_i = p1_src;
    assign p2_i = res(p2_o, p2_oe_n, ext_en, ext_val);
    assign p3_i = res(p3_o, p3_oe_n, ext_en, ext_val);
endmodule
`default_nettype wire
